// >>> pmr_defines.svh
// Register offsets, field positions, reset values and timing counts of the management register set
`ifndef PMR_DEFINES_SVH
`define PMR_DEFINES_SVH

`define PMR_ADDR_CONTROL 5'h00
`define PMR_ADDR_STATUS 5'h01
`define PMR_ADDR_ID_HIGH 5'h02
`define PMR_ADDR_ID_LOW 5'h03
`define PMR_ADDR_ADVERTISE 5'h04
`define PMR_ADDR_PARTNER 5'h05
`define PMR_ADDR_EXPANSION 5'h06
`define PMR_ADDR_NP_TX 5'h07
`define PMR_ADDR_PARTNER_NP 5'h08
`define PMR_ADDR_RSVD_LAST 5'h0F

`define PMR_CTL_RESET 15
`define PMR_CTL_LOOPBACK 14
`define PMR_CTL_SPEED 13
`define PMR_CTL_NEG_EN 12
`define PMR_CTL_LOW_POWER 11
`define PMR_CTL_ISOLATE 10
`define PMR_CTL_NEG_RESTART 9
`define PMR_CTL_DUPLEX 8
`define PMR_CTL_COL_TEST 7

`define PMR_CONTROL_RESET 16'h3100
`define PMR_STATUS_FIXED 16'h7809
`define PMR_ADVERTISE_RESET 16'h01E1
`define PMR_ADV_RW_MASK 16'hA1E0
`define PMR_NP_TX_RESET 16'h2001

`define PMR_STS_NEG_DONE 5
`define PMR_STS_REMOTE_FAULT 4
`define PMR_STS_LINK 2
`define PMR_STS_JABBER 1

// Length of the internal reset pulse started by control bit 15
`define PMR_SOFT_RESET_NS 1000
`define PMR_SOFT_RESET_CYCLES ((`PMR_SOFT_RESET_NS + 9) / 10)

`endif

// >>> pmr_pkg.sv
// Types of the management register set
package pmr_pkg;
	typedef logic [4:0] pmr_addr_t;
	typedef logic [15:0] pmr_word_t;
	typedef enum logic [1:0] {
		PMR_RUN = 2'b00,
		PMR_SOFT_RESET = 2'b01
	} pmr_reset_state_e;
endpackage : pmr_pkg

// >>> pmr_register_set.sv
// Management register set of a 10/100 Ethernet transceiver
// Function
// - Control bit 15 self-clearing reset; writing zero does nothing; reads zero by default
// - Control bit 14 loopback enable, read/write, default zero
// - Control bit 13 speed select, one is 100 Mbps, default one
// - Control bit 12 link negotiation enable, read/write, default one
// - Control bit 11 low-power mode, read/write, default zero
// - Control bit 10 isolates from media interface, default zero
// - Control bit 9 self-clearing negotiation restart, default zero
// - Control bit 8 full duplex when one, default one
// - Control bit 7 collision test enable, default zero
// - Control bits 6..0 read zero; control default 0x3100
// - Status bit 15 always reads zero
// - Status bits 14..11 read one; bits 10..7 read zero
// - Status bit 6 reads zero; controller must always send preamble
// - Status bit 5 negotiation complete, latched high, default zero
// - Status bit 4 remote fault, latched high, read-only
// - Status bits 3 and 0 always read one
// - Status bit 2 link valid, latched low, default zero
// - Status bit 1 jabber detected, latched high, default zero
// - Addresses 4 to 8 decode the negotiation registers
// - Addresses 9 to 15 reserved; 16 to 31 maker-specific extended
// - Advertisement defaults: four abilities advertised, selector 00001
`timescale 1ns/1ps
`include "pmr_defines.svh"

module pmr_register_set #(
	parameter logic [21:0] ORG_ID = 22'h000000, // Arbitrary value
	parameter logic [5:0] MODEL_NUM = 6'h00, // Arbitrary value
	parameter logic [3:0] REV_NUM = 4'h0, // Arbitrary value
	parameter int SOFT_RESET_CYCLES = `PMR_SOFT_RESET_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port from the management frame engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire pmr_pkg::pmr_addr_t reg_addr,
	input wire pmr_pkg::pmr_word_t reg_wdata,
	output pmr_pkg::pmr_word_t reg_rdata,
	// Maker-specific register space, addresses 16 to 31
	output logic ext_sel,
	input wire pmr_pkg::pmr_word_t ext_rdata,
	// Live state from the line side
	input wire logic line_neg_done,
	input wire logic line_remote_fault,
	input wire logic line_link_up,
	input wire logic line_jabber,
	input wire pmr_pkg::pmr_word_t line_partner_ability,
	input wire pmr_pkg::pmr_word_t line_expansion,
	input wire pmr_pkg::pmr_word_t line_partner_np,
	// Controls to the datapath
	output logic soft_reset,
	output logic loopback_en,
	output logic speed_100,
	output logic neg_enable,
	output logic low_power,
	output logic isolate,
	output logic neg_restart,
	output logic full_duplex,
	output logic col_test,
	output pmr_pkg::pmr_word_t advertise,
	output pmr_pkg::pmr_word_t np_transmit
);
	import pmr_pkg::*;

	// Line inputs come from another domain
	logic [3:0] line_meta_reg;
	logic [3:0] line_sync_reg;
	pmr_reset_state_e rst_state_reg;
	logic [31:0] rst_cnt_reg;
	pmr_word_t control_reg;
	pmr_word_t advertise_reg;
	pmr_word_t np_tx_reg;
	logic neg_done_reg;
	logic remote_fault_reg;
	logic link_reg;
	logic jabber_reg;
	logic restart_reg;
	logic wr_ctl;
	logic rd_sts;
	logic reset_done;
	pmr_word_t status_word;
	pmr_word_t rdata_next;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_meta_reg <= 4'h0;
			line_sync_reg <= 4'h0;
		end else begin
			line_meta_reg <= {line_neg_done, line_remote_fault, line_link_up, line_jabber};
			line_sync_reg <= line_meta_reg;
		end
	end

	assign wr_ctl = reg_wr && (reg_addr == `PMR_ADDR_CONTROL);
	assign rd_sts = reg_rd && (reg_addr == `PMR_ADDR_STATUS);
	assign reset_done = (rst_state_reg == PMR_SOFT_RESET) && (rst_cnt_reg == 32'h0);

	// Software reset sequencer; bit 15 stays one until the pulse ends
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_state_reg <= PMR_RUN;
			rst_cnt_reg <= 32'h0;
		end else begin
			unique case (rst_state_reg)
				PMR_RUN: begin
					if (wr_ctl && reg_wdata[`PMR_CTL_RESET]) begin
						rst_state_reg <= PMR_SOFT_RESET;
						rst_cnt_reg <= 32'(SOFT_RESET_CYCLES - 1);
					end
				end
				PMR_SOFT_RESET: begin
					if (rst_cnt_reg == 32'h0) begin
						rst_state_reg <= PMR_RUN;
					end else begin
						rst_cnt_reg <= rst_cnt_reg - 32'h1;
					end
				end
				default: begin
					rst_state_reg <= PMR_RUN;
				end
			endcase
		end
	end

	// Control register; the soft reset pulse returns it to defaults
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_reg <= `PMR_CONTROL_RESET;
		end else if (reset_done) begin
			control_reg <= `PMR_CONTROL_RESET;
		end else if (rst_state_reg == PMR_SOFT_RESET) begin
			control_reg[`PMR_CTL_RESET] <= 1'b1;
		end else if (wr_ctl) begin
			control_reg[`PMR_CTL_RESET] <= reg_wdata[`PMR_CTL_RESET];
			control_reg[`PMR_CTL_LOOPBACK] <= reg_wdata[`PMR_CTL_LOOPBACK];
			control_reg[`PMR_CTL_SPEED] <= reg_wdata[`PMR_CTL_SPEED];
			control_reg[`PMR_CTL_NEG_EN] <= reg_wdata[`PMR_CTL_NEG_EN];
			control_reg[`PMR_CTL_LOW_POWER] <= reg_wdata[`PMR_CTL_LOW_POWER];
			control_reg[`PMR_CTL_ISOLATE] <= reg_wdata[`PMR_CTL_ISOLATE];
			control_reg[`PMR_CTL_NEG_RESTART] <= 1'b0;
			control_reg[`PMR_CTL_DUPLEX] <= reg_wdata[`PMR_CTL_DUPLEX];
			control_reg[`PMR_CTL_COL_TEST] <= reg_wdata[`PMR_CTL_COL_TEST];
			control_reg[6:0] <= 7'h00;
		end
	end

	// Restart is a one-cycle pulse, so bit 9 always reads back zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= wr_ctl && reg_wdata[`PMR_CTL_NEG_RESTART]
				&& (rst_state_reg == PMR_RUN);
		end
	end

	// Advertisement and next-page transmit registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			advertise_reg <= `PMR_ADVERTISE_RESET;
			np_tx_reg <= `PMR_NP_TX_RESET;
		end else if (reset_done) begin
			advertise_reg <= `PMR_ADVERTISE_RESET;
			np_tx_reg <= `PMR_NP_TX_RESET;
		end else if (reg_wr && (reg_addr == `PMR_ADDR_ADVERTISE)) begin
			advertise_reg <= (reg_wdata & `PMR_ADV_RW_MASK)
				| (`PMR_ADVERTISE_RESET & ~`PMR_ADV_RW_MASK);
		end else if (reg_wr && (reg_addr == `PMR_ADDR_NP_TX)) begin
			np_tx_reg <= reg_wdata;
		end
	end

	// Latched bits: the event wins over the clear that a status read makes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			neg_done_reg <= 1'b0;
			remote_fault_reg <= 1'b0;
			jabber_reg <= 1'b0;
			link_reg <= 1'b0;
		end else if (rd_sts) begin
			neg_done_reg <= line_sync_reg[3];
			remote_fault_reg <= line_sync_reg[2];
			link_reg <= line_sync_reg[1];
			jabber_reg <= line_sync_reg[0];
		end else begin
			neg_done_reg <= neg_done_reg | line_sync_reg[3];
			remote_fault_reg <= remote_fault_reg | line_sync_reg[2];
			link_reg <= link_reg & line_sync_reg[1];
			jabber_reg <= jabber_reg | line_sync_reg[0];
		end
	end

	always_comb begin
		status_word = `PMR_STATUS_FIXED;
		status_word[`PMR_STS_NEG_DONE] = neg_done_reg;
		status_word[`PMR_STS_REMOTE_FAULT] = remote_fault_reg;
		status_word[`PMR_STS_LINK] = link_reg;
		status_word[`PMR_STS_JABBER] = jabber_reg;
	end

	// Read mux; reserved addresses read zero
	always_comb begin
		rdata_next = 16'h0000;
		if (reg_addr > `PMR_ADDR_RSVD_LAST) begin
			rdata_next = ext_rdata;
		end else begin
			unique case (reg_addr)
				`PMR_ADDR_CONTROL: rdata_next = control_reg;
				`PMR_ADDR_STATUS: rdata_next = status_word;
				`PMR_ADDR_ID_HIGH: rdata_next = ORG_ID[21:6];
				`PMR_ADDR_ID_LOW: rdata_next = {ORG_ID[5:0], MODEL_NUM, REV_NUM};
				`PMR_ADDR_ADVERTISE: rdata_next = advertise_reg;
				`PMR_ADDR_PARTNER: rdata_next = line_partner_ability;
				`PMR_ADDR_EXPANSION: rdata_next = line_expansion;
				`PMR_ADDR_NP_TX: rdata_next = np_tx_reg;
				`PMR_ADDR_PARTNER_NP: rdata_next = line_partner_np;
				default: rdata_next = 16'h0000;
			endcase
		end
	end

	// Read data is sampled when the read strobe is taken
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= rdata_next;
		end
	end

	assign ext_sel = (reg_rd || reg_wr) && (reg_addr > `PMR_ADDR_RSVD_LAST);
	assign soft_reset = control_reg[`PMR_CTL_RESET];
	assign loopback_en = control_reg[`PMR_CTL_LOOPBACK];
	assign speed_100 = control_reg[`PMR_CTL_SPEED];
	assign neg_enable = control_reg[`PMR_CTL_NEG_EN];
	assign low_power = control_reg[`PMR_CTL_LOW_POWER];
	assign isolate = control_reg[`PMR_CTL_ISOLATE];
	assign neg_restart = restart_reg;
	assign full_duplex = control_reg[`PMR_CTL_DUPLEX];
	assign col_test = control_reg[`PMR_CTL_COL_TEST];
	assign advertise = advertise_reg;
	assign np_transmit = np_tx_reg;
endmodule : pmr_register_set

// >>> pmr_register_set_sva.sv
// Checker for the management register port and control outputs
`timescale 1ns/1ps
module pmr_register_set_sva (
	// Register port
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire pmr_pkg::pmr_addr_t reg_addr,
	input wire pmr_pkg::pmr_word_t reg_wdata,
	input wire pmr_pkg::pmr_word_t reg_rdata,
	input wire logic ext_sel,
	// Controls
	input wire logic soft_reset,
	input wire logic loopback_en,
	input wire logic neg_restart
);
	import pmr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Control writes during a soft reset pulse are dropped, so they must not count as causes
	wire logic wr_ctl = reg_wr && reg_addr == 5'h00 && !soft_reset;
	AST_SOFT_START: assert property (wr_ctl && reg_wdata[15] |=> soft_reset)
		else $error("soft reset did not start");
	AST_SOFT_END: assert property ($rose(soft_reset) |-> ##[1:200] !soft_reset)
		else $error("soft reset did not clear");
	AST_RESTART: assert property (wr_ctl && reg_wdata[9] && !reg_wdata[15] |=> neg_restart)
		else $error("restart pulse missing");
	AST_RESTART_CAUSE: assert property (!(wr_ctl && reg_wdata[9]) |=> !neg_restart)
		else $error("restart pulse without a write");
	AST_LOOPBACK: assert property (wr_ctl && !reg_wdata[15] |=> loopback_en == $past(reg_wdata[14]))
		else $error("loopback does not follow write");
	AST_EXT_SEL: assert property (ext_sel == ((reg_rd || reg_wr) && reg_addr[4]))
		else $error("extended select wrong");
	AST_RSVD_ZERO: assert property (reg_rd && reg_addr inside {[5'h09:5'h0F]}
		|=> reg_rdata == 16'h0000) else $error("reserved address not zero");
	AST_STATUS_FIXED: assert property (reg_rd && reg_addr == 5'h01
		|=> (reg_rdata & 16'hFFC9) == 16'h7809) else $error("status fixed bits wrong");
	AST_CTL_RSVD: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata[6:0] == 7'h00)
		else $error("control low bits not zero");
endmodule : pmr_register_set_sva
bind pmr_register_set pmr_register_set_sva u_sva (.clk(clk), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.ext_sel(ext_sel), .soft_reset(soft_reset), .loopback_en(loopback_en),
	.neg_restart(neg_restart));

// >>> pmr_sta_model.sv
// Station management controller model driving the register port
`timescale 1ns/1ps
module pmr_sta_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output pmr_pkg::pmr_addr_t reg_addr = 5'h1F,
	output pmr_pkg::pmr_word_t reg_wdata = 16'h0000,
	input wire pmr_pkg::pmr_word_t reg_rdata
);
	import pmr_pkg::*;
	// A whole frame, preamble always sent, collapses to one strobe here
	task automatic wr(input pmr_addr_t a, input pmr_word_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input pmr_addr_t a, output pmr_word_t d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd
endmodule : pmr_sta_model

// >>> pmr_register_set_bench.sv
// Self-checking bench for the management register set
`timescale 1ns/1ps
module pmr_register_set_bench;
	import pmr_pkg::*;
	logic clk, rst, reg_wr, reg_rd, ext_sel, soft_reset, loopback_en, speed_100, neg_enable;
	logic low_power, isolate, neg_restart, full_duplex, col_test;
	logic [3:0] line, lat_m;
	pmr_addr_t reg_addr;
	pmr_word_t reg_wdata, reg_rdata, ext_rdata, part_ab, expan, part_np, adv, np_tx;
	pmr_word_t got, w, ctl_m, adv_m;
	pmr_addr_t ro [9] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0C, 5'h0F};
	integer seed = 53, fail_count = 0, n_compared = 0, cyc = 0;
	pmr_register_set #(.SOFT_RESET_CYCLES(2)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.ext_sel(ext_sel), .ext_rdata(ext_rdata), .line_neg_done(line[3]),
		.line_remote_fault(line[2]), .line_link_up(line[1]), .line_jabber(line[0]),
		.line_partner_ability(part_ab), .line_expansion(expan), .line_partner_np(part_np),
		.soft_reset(soft_reset), .loopback_en(loopback_en), .speed_100(speed_100),
		.neg_enable(neg_enable), .low_power(low_power), .isolate(isolate),
		.neg_restart(neg_restart), .full_duplex(full_duplex), .col_test(col_test),
		.advertise(adv), .np_transmit(np_tx));
	pmr_sta_model sta (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic check(input pmr_word_t g, input pmr_word_t e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask : check
	function automatic pmr_word_t exp_of(input int a);
		if (a >= 16)
			return ext_rdata;
		case (a)
			0: return ctl_m;
			4: return adv_m;
			5: return part_ab;
			6: return expan;
			7: return 16'h2001;
			8: return part_np;
			default: return 16'h0000;
		endcase
	endfunction : exp_of
	task automatic map_check();
		for (int a = 0; a < 32; a++) begin
			if (a != 1) begin
				sta.rd(5'(a), got);
				check(got, exp_of(a));
			end
		end
		$display("map test done");
	endtask : map_check
	// Latched bits: high ones collect events, the low one collects losses
	task automatic set_line(input logic [3:0] v);
		@(posedge clk);
		line <= v;
		repeat (6) @(posedge clk);
		lat_m = (lat_m | (v & 4'b1101)) & (v | 4'b1101);
	endtask : set_line
	task automatic rd_status();
		sta.rd(5'h01, got);
		check(got, 16'h7809 | {10'h000, lat_m[3:2], 1'b0, lat_m[1:0], 1'b0});
		lat_m = line;
	endtask : rd_status
	initial begin
		rst = 1'b1;
		line = 4'b0010;
		lat_m = 4'b0000;
		{ext_rdata, part_ab, expan, part_np} = '0;
		ctl_m = 16'h3100;
		adv_m = 16'h01E1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		ext_rdata <= 16'($random(seed));
		part_ab <= 16'($random(seed));
		expan <= 16'($random(seed));
		part_np <= 16'($random(seed));
		map_check();
		for (int i = 0; i < 20; i++) begin
			w = 16'($random(seed));
			w[15] = 1'b0;
			sta.wr(5'h00, w);
			#1 check({15'h0000, neg_restart}, {15'h0000, w[9]});
			ctl_m = w & 16'h7D80;
			sta.rd(5'h00, got);
			check(got, ctl_m);
			check({9'h000, loopback_en, speed_100, neg_enable, low_power, isolate, full_duplex,
				col_test}, {9'h000, ctl_m[14:10], ctl_m[8:7]});
			sta.wr(ro[i % 9], ~w);
			sta.wr(5'h04, ~w);
			adv_m = (~w & 16'hA1E0) | 16'h0001;
			#1 check(adv, adv_m);
			check(np_tx, 16'h2001);
		end
		$display("control test done");
		map_check();
		rd_status();
		rd_status();
		set_line(4'b1111);
		set_line(4'b0000);
		rd_status();
		rd_status();
		set_line(4'b0010);
		rd_status();
		rd_status();
		$display("status test done");
		sta.wr(5'h00, 16'hC000);
		#1 check({15'h0000, soft_reset}, 16'h0001);
		repeat (10) @(posedge clk);
		ctl_m = 16'h3100;
		adv_m = 16'h01E1;
		map_check();
		check(adv, 16'h01E1);
		check({15'h0000, soft_reset}, 16'h0000);
		tally_and_finish();
	end
endmodule : pmr_register_set_bench
